// *** shared/cims_consts.svh ***
// Offsets, command codes, reset values and field positions of the channel I/O mode select block
`ifndef CIMS_CONSTS_SVH
`define CIMS_CONSTS_SVH

// ***************************************************************
// Register offsets (byte addresses)
// ***************************************************************
`define CIMS_OFS_CMD_A 8'h00
`define CIMS_OFS_CMD_B 8'h04
`define CIMS_OFS_STATUS 8'h08
`define CIMS_OFS_PINFN 8'h0c

// ***************************************************************
// Set-bit-mode command values
// ***************************************************************
`define CIMS_CMD_RESET 8'h00
`define CIMS_CMD_ASYNC_BB 8'h01
`define CIMS_CMD_MULTI_PROTOCOL_SERIAL_ENGINE 8'h02
`define CIMS_CMD_SYNC_BB 8'h04
`define CIMS_CMD_MCU 8'h08
`define CIMS_CMD_FSI 8'h10

// ***************************************************************
// Strobe placement on the control bus, as output enable masks
// ***************************************************************
`define CIMS_STB_MASK_LOW 4'h3
`define CIMS_STB_MASK_HIGH 4'hc
`define CIMS_STB_NONE 4'h0
`define CIMS_STB_IDLE 4'hf

// ***************************************************************
// Status field positions and reset values
// ***************************************************************
`define CIMS_ST_MAIN_A_LSB 0
`define CIMS_ST_MAIN_B_LSB 2
`define CIMS_ST_HOLD_LSB 4
`define CIMS_ST_BOTH_FSI 6
`define CIMS_ST_BM_A_LSB 8
`define CIMS_ST_BM_B_LSB 12
`define CIMS_PF_B_LSB 4
`define CIMS_RST_CMD 8'h00
`define CIMS_RST_DATA 32'h0000_0000

`endif

// *** shared/cims_pkg.sv ***
// Types of the channel I/O mode select block
package cims_pkg;

	// Main mode taken from configuration memory
	typedef enum logic [1:0] {
		CIMS_MAIN_UART = 2'b00,
		CIMS_MAIN_BYTE_FIFO = 2'b01,
		CIMS_MAIN_CPU_FIFO = 2'b10,
		CIMS_MAIN_FSI = 2'b11
	} cims_main_t;

	// Overlay mode entered by command
	typedef enum logic [2:0] {
		CIMS_BM_NONE = 3'b000,
		CIMS_BM_ASYNC = 3'b001,
		CIMS_BM_MULTI_PROTOCOL_SERIAL_ENGINE = 3'b010,
		CIMS_BM_SYNC = 3'b011,
		CIMS_BM_MCU = 3'b100
	} cims_bm_t;

	// Resolved pin function of one channel
	typedef enum logic [3:0] {
		CIMS_PF_UART = 4'b0000,
		CIMS_PF_BYTE_FIFO = 4'b0001,
		CIMS_PF_CPU_FIFO = 4'b0010,
		CIMS_PF_FSI = 4'b0011,
		CIMS_PF_ASYNC_BB = 4'b0100,
		CIMS_PF_SYNC_BB = 4'b0101,
		CIMS_PF_MULTI_PROTOCOL_SERIAL_ENGINE = 4'b0110,
		CIMS_PF_MCU = 4'b0111,
		CIMS_PF_IDLE = 4'b1000
	} cims_pf_t;

endpackage

// *** shared/cims_strobe_if.sv ***
// Carrier between the mode selector and a strobe router
`timescale 1ns/1ps
`default_nettype none

interface cims_strobe_if;
	logic bb_active;
	logic uart_main;
	logic wr_strobe;
	logic rd_strobe;
	logic [3:0] ctrl_bus;
	logic [3:0] ctrl_oe;

	// Mode selector side
	modport ctl (output bb_active, output uart_main, output wr_strobe, output rd_strobe,
		input ctrl_bus, input ctrl_oe);
	// Router side
	modport rt (input bb_active, input uart_main, input wr_strobe, input rd_strobe,
		output ctrl_bus, output ctrl_oe);
endinterface

`default_nettype wire

// *** rtl/cims_strobe_route.sv ***
// Places the bit-bang write and read strobes on the control bus of one channel
`timescale 1ns/1ps
`default_nettype none
`include "cims_consts.svh"

module cims_strobe_route (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Mode selector link
	cims_strobe_if.rt s
);
	logic [3:0] bus;
	logic [3:0] oe;
	logic [3:0] next_bus;
	logic [3:0] next_oe;

	// Strobes are active low; undriven bits stay at the idle level
	always_comb begin
		next_bus = `CIMS_STB_IDLE;
		next_oe = `CIMS_STB_NONE;
		if (s.bb_active) begin
			if (s.uart_main) begin
				// [R09] UART main, bits two and three
				next_bus[2] = ~s.wr_strobe;
				next_bus[3] = ~s.rd_strobe;
				next_oe = `CIMS_STB_MASK_HIGH;
			end else begin
				// [R08] FIFO main, bits zero and one
				next_bus[0] = ~s.wr_strobe;
				next_bus[1] = ~s.rd_strobe;
				next_oe = `CIMS_STB_MASK_LOW;
			end
		end
	end

	// Registered so the pins never glitch on a mode change
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			bus <= `CIMS_STB_IDLE;
			oe <= `CIMS_STB_NONE;
		end else begin
			bus <= next_bus;
			oe <= next_oe;
		end
	end

	assign s.ctrl_bus = bus;
	assign s.ctrl_oe = oe;
endmodule

`default_nettype wire

// *** rtl/cims_mode_select.sv ***
// Per-channel I/O mode selection and pin-function multiplexing for a dual-channel bridge
//
// Overview of operation
// [R01] Main modes come from configuration memory; overlay modes only from commands.
// [R02] Command 0 resets bit mode, 1 async bit-bang, 2 serial engine.
// [R03] Command 4 sync bit-bang, 8 bus emulation, 10 hex isolated serial.
// [R04] With isolated serial main, 10 holds it in reset, 0 releases.
// [R05] Serial engine only on first channel; request on second is ignored.
// [R06] Bus emulation takes both channels; no independent mode meanwhile.
// [R07] Both channels isolated serial puts all its signals on second channel.
// [R08] Bit-bang with FIFO main: write strobe bit 0, read strobe bit 1.
// [R09] Bit-bang with UART main: write strobe bit 2, read strobe bit 3.
// [R10] No bit-bang on second channel while isolated serial is its main mode.
// [R11] Wake pin off in serial engine, bus emulation, CPU FIFO modes.
// [R12] Missing or blank configuration memory starts both channels in UART.
// [R13] Bit mode reset returns pins to main mode, strobes removed.
// [R14] Unknown or forbidden command value leaves the channel unchanged.
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cims_consts.svh"

module cims_mode_select (
	// Clock and reset
	input wire logic I_CORE_CLK,
	input wire logic I_SYS_RST,
	// Configuration memory
	input wire logic I_CFG_LOAD,
	input wire logic I_CFG_PRESENT,
	input wire logic I_CFG_BLANK,
	input wire logic [1:0] I_CFG_MODE_A,
	input wire logic [1:0] I_CFG_MODE_B,
	// Register port
	input wire logic [7:0] I_ADDR,
	input wire logic [31:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [31:0] O_RDATA,
	// Bit-bang strobes from the datapaths
	input wire logic I_BB_WR_A,
	input wire logic I_BB_RD_A,
	input wire logic I_BB_WR_B,
	input wire logic I_BB_RD_B,
	// Control bus strobes
	output logic [3:0] O_FIRST_CHANNEL_CONTROL_BUS,
	output logic [3:0] O_FIRST_CHANNEL_CONTROL_BUS_OE,
	output logic [3:0] O_SECOND_CHANNEL_CONTROL_BUS,
	output logic [3:0] O_SECOND_CHANNEL_CONTROL_BUS_OE,
	// Resolved functions
	output logic [3:0] O_PIN_FUNC_A,
	output logic [3:0] O_PIN_FUNC_B,
	output logic O_SEND_NOW_WAKE_PIN_FIRST_EN,
	output logic O_SEND_NOW_WAKE_PIN_SECOND_EN,
	output logic [1:0] O_FSI_HOLD,
	output logic O_FSI_ON_SECOND
);
	// ***************************************************************
	// State
	// ***************************************************************
	cims_pkg::cims_main_t main_a, main_b, next_main_a, next_main_b;
	cims_pkg::cims_bm_t bm_a, bm_b, next_bm_a, next_bm_b;
	logic [1:0] hold, next_hold;
	logic [7:0] last_a, last_b, next_last_a, next_last_b;
	logic [31:0] rdata, next_rdata;
	cims_pkg::cims_pf_t pf_a, pf_b, next_pf_a, next_pf_b;
	logic wake_a, wake_b, next_wake_a, next_wake_b;
	logic both_fsi;
	logic on_sec, next_on_sec;

	cims_strobe_if sa ();
	cims_strobe_if sb ();

	// Resolve one channel's pin function from main and overlay modes
	function automatic cims_pkg::cims_pf_t pin_func(input cims_pkg::cims_main_t m,
		input cims_pkg::cims_bm_t b, input logic is_b, input logic fsi2);
		cims_pkg::cims_pf_t f;
		f = cims_pkg::CIMS_PF_UART;
		unique case (b)
			cims_pkg::CIMS_BM_MCU: f = cims_pkg::CIMS_PF_MCU;
			cims_pkg::CIMS_BM_MULTI_PROTOCOL_SERIAL_ENGINE: f = cims_pkg::CIMS_PF_MULTI_PROTOCOL_SERIAL_ENGINE;
			cims_pkg::CIMS_BM_ASYNC: f = cims_pkg::CIMS_PF_ASYNC_BB;
			cims_pkg::CIMS_BM_SYNC: f = cims_pkg::CIMS_PF_SYNC_BB;
			default: begin
				// [R13] Back to the configured main function
				unique case (m)
					cims_pkg::CIMS_MAIN_UART: f = cims_pkg::CIMS_PF_UART;
					cims_pkg::CIMS_MAIN_BYTE_FIFO: f = cims_pkg::CIMS_PF_BYTE_FIFO;
					cims_pkg::CIMS_MAIN_CPU_FIFO: f = cims_pkg::CIMS_PF_CPU_FIFO;
					cims_pkg::CIMS_MAIN_FSI: f = cims_pkg::CIMS_PF_FSI;
				endcase
				// [R07] Both isolated: first channel pins are released
				if (fsi2 && !is_b)
					f = cims_pkg::CIMS_PF_IDLE;
			end
		endcase
		return f;
	endfunction

	// Wake pin is usable only outside the listed modes
	function automatic logic wake_ok(input cims_pkg::cims_main_t m, input cims_pkg::cims_bm_t b,
		input logic is_b);
		// [R11] Disabled in engine, emulation, CPU FIFO; isolated kept on second only
		return !(b == cims_pkg::CIMS_BM_MULTI_PROTOCOL_SERIAL_ENGINE || b == cims_pkg::CIMS_BM_MCU ||
			m == cims_pkg::CIMS_MAIN_CPU_FIFO || (m == cims_pkg::CIMS_MAIN_FSI && !is_b));
	endfunction

	// ***************************************************************
	// Command decode and mode state
	// ***************************************************************
	// A configuration reload drops any overlay, so the new main mode starts clean
	always_comb begin
		logic is_b;
		logic ok;
		logic mcu_on;
		logic [7:0] v;
		cims_pkg::cims_main_t ms;
		is_b = (I_ADDR == `CIMS_OFS_CMD_B);
		ok = 1'b0;
		mcu_on = (bm_a == cims_pkg::CIMS_BM_MCU);
		v = I_WDATA[7:0];
		ms = is_b ? main_b : main_a;
		next_main_a = main_a;
		next_main_b = main_b;
		next_bm_a = bm_a;
		next_bm_b = bm_b;
		next_hold = hold;
		next_last_a = last_a;
		next_last_b = last_b;
		if (I_CFG_LOAD) begin
			// [R12] No memory or blank memory gives UART on both
			if (!I_CFG_PRESENT || I_CFG_BLANK) begin
				next_main_a = cims_pkg::CIMS_MAIN_UART;
				next_main_b = cims_pkg::CIMS_MAIN_UART;
			end else begin
				// [R01] Main modes only from configuration memory
				next_main_a = cims_pkg::cims_main_t'(I_CFG_MODE_A);
				next_main_b = cims_pkg::cims_main_t'(I_CFG_MODE_B);
			end
			next_bm_a = cims_pkg::CIMS_BM_NONE;
			next_bm_b = cims_pkg::CIMS_BM_NONE;
			next_hold = 2'b00;
		end else if (I_WR && (I_ADDR == `CIMS_OFS_CMD_A || is_b)) begin
			if (v == `CIMS_CMD_RESET) begin
				// [R02] Reset bit mode; emulation is cleared on both channels
				ok = 1'b1;
				if (mcu_on || !is_b)
					next_bm_a = cims_pkg::CIMS_BM_NONE;
				if (mcu_on || is_b)
					next_bm_b = cims_pkg::CIMS_BM_NONE;
				// [R04] Release isolated serial from reset
				if (ms == cims_pkg::CIMS_MAIN_FSI)
					next_hold[is_b] = 1'b0;
			end else if (!mcu_on) begin
				// [R06] While emulation runs only reset is taken
				unique case (v)
					`CIMS_CMD_ASYNC_BB, `CIMS_CMD_SYNC_BB: begin
						// [R10] Refused on second channel when isolated main
						ok = !(is_b && main_b == cims_pkg::CIMS_MAIN_FSI);
						if (ok && is_b)
							next_bm_b = (v == `CIMS_CMD_SYNC_BB) ? cims_pkg::CIMS_BM_SYNC :
								cims_pkg::CIMS_BM_ASYNC;
						// [R03] Synchronous bit-bang code
						if (ok && !is_b)
							next_bm_a = (v == `CIMS_CMD_SYNC_BB) ? cims_pkg::CIMS_BM_SYNC :
								cims_pkg::CIMS_BM_ASYNC;
					end
					`CIMS_CMD_MULTI_PROTOCOL_SERIAL_ENGINE: begin
						// [R05] Serial engine on the first channel only
						ok = !is_b;
						if (ok)
							next_bm_a = cims_pkg::CIMS_BM_MULTI_PROTOCOL_SERIAL_ENGINE;
					end
					`CIMS_CMD_MCU: begin
						// [R06] Emulation occupies both channels
						ok = 1'b1;
						next_bm_a = cims_pkg::CIMS_BM_MCU;
						next_bm_b = cims_pkg::CIMS_BM_MCU;
					end
					`CIMS_CMD_FSI: begin
						// [R04] Hold isolated serial in reset
						ok = (ms == cims_pkg::CIMS_MAIN_FSI);
						if (ok)
							next_hold[is_b] = 1'b1;
					end
					// [R14] Anything else changes nothing
					default: ok = 1'b0;
				endcase
			end
			if (ok && is_b)
				next_last_b = v;
			if (ok && !is_b)
				next_last_a = v;
		end
	end

	// Mode registers; UART default covers power-up before any load
	always_ff @(posedge I_CORE_CLK) begin
		if (I_SYS_RST) begin
			main_a <= cims_pkg::CIMS_MAIN_UART;
			main_b <= cims_pkg::CIMS_MAIN_UART;
			bm_a <= cims_pkg::CIMS_BM_NONE;
			bm_b <= cims_pkg::CIMS_BM_NONE;
			hold <= 2'b00;
			last_a <= `CIMS_RST_CMD;
			last_b <= `CIMS_RST_CMD;
		end else begin
			main_a <= next_main_a;
			main_b <= next_main_b;
			bm_a <= next_bm_a;
			bm_b <= next_bm_b;
			hold <= next_hold;
			last_a <= next_last_a;
			last_b <= next_last_b;
		end
	end

	// ***************************************************************
	// Pin function outputs and read data
	// ***************************************************************
	assign both_fsi = (main_a == cims_pkg::CIMS_MAIN_FSI) && (main_b == cims_pkg::CIMS_MAIN_FSI);

	// Unmapped reads return zero; read data follow the strobe by one cycle
	always_comb begin
		next_pf_a = pin_func(main_a, bm_a, 1'b0, both_fsi);
		next_pf_b = pin_func(main_b, bm_b, 1'b1, both_fsi);
		next_wake_a = wake_ok(main_a, bm_a, 1'b0);
		next_wake_b = wake_ok(main_b, bm_b, 1'b1);
		next_on_sec = both_fsi;
		next_rdata = `CIMS_RST_DATA;
		if (I_RD) begin
			unique case (I_ADDR)
				`CIMS_OFS_CMD_A: next_rdata[7:0] = last_a;
				`CIMS_OFS_CMD_B: next_rdata[7:0] = last_b;
				`CIMS_OFS_STATUS: begin
					next_rdata[`CIMS_ST_MAIN_A_LSB +: 2] = main_a;
					next_rdata[`CIMS_ST_MAIN_B_LSB +: 2] = main_b;
					next_rdata[`CIMS_ST_HOLD_LSB +: 2] = hold;
					next_rdata[`CIMS_ST_BOTH_FSI] = both_fsi;
					next_rdata[`CIMS_ST_BM_A_LSB +: 3] = bm_a;
					next_rdata[`CIMS_ST_BM_B_LSB +: 3] = bm_b;
				end
				`CIMS_OFS_PINFN: begin
					next_rdata[3:0] = pf_a;
					next_rdata[`CIMS_PF_B_LSB +: 4] = pf_b;
				end
				default: next_rdata = `CIMS_RST_DATA;
			endcase
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (I_SYS_RST) begin
			pf_a <= cims_pkg::CIMS_PF_UART;
			pf_b <= cims_pkg::CIMS_PF_UART;
			wake_a <= 1'b1;
			wake_b <= 1'b1;
			on_sec <= 1'b0;
			rdata <= `CIMS_RST_DATA;
		end else begin
			pf_a <= next_pf_a;
			pf_b <= next_pf_b;
			wake_a <= next_wake_a;
			wake_b <= next_wake_b;
			on_sec <= next_on_sec;
			rdata <= next_rdata;
		end
	end

	// ***************************************************************
	// Strobe routing per channel
	// ***************************************************************
	assign sa.bb_active = (bm_a == cims_pkg::CIMS_BM_ASYNC) || (bm_a == cims_pkg::CIMS_BM_SYNC);
	assign sa.uart_main = (main_a == cims_pkg::CIMS_MAIN_UART);
	assign sa.wr_strobe = I_BB_WR_A;
	assign sa.rd_strobe = I_BB_RD_A;
	assign sb.bb_active = (bm_b == cims_pkg::CIMS_BM_ASYNC) || (bm_b == cims_pkg::CIMS_BM_SYNC);
	assign sb.uart_main = (main_b == cims_pkg::CIMS_MAIN_UART);
	assign sb.wr_strobe = I_BB_WR_B;
	assign sb.rd_strobe = I_BB_RD_B;

	cims_strobe_route u_route_a (.i_clk(I_CORE_CLK), .i_rst(I_SYS_RST), .s(sa.rt));
	cims_strobe_route u_route_b (.i_clk(I_CORE_CLK), .i_rst(I_SYS_RST), .s(sb.rt));

	// Outputs, each from a flip-flop here or in a router
	assign O_RDATA = rdata;
	assign O_FIRST_CHANNEL_CONTROL_BUS = sa.ctrl_bus;
	assign O_FIRST_CHANNEL_CONTROL_BUS_OE = sa.ctrl_oe;
	assign O_SECOND_CHANNEL_CONTROL_BUS = sb.ctrl_bus;
	assign O_SECOND_CHANNEL_CONTROL_BUS_OE = sb.ctrl_oe;
	assign O_PIN_FUNC_A = pf_a;
	assign O_PIN_FUNC_B = pf_b;
	assign O_SEND_NOW_WAKE_PIN_FIRST_EN = wake_a;
	assign O_SEND_NOW_WAKE_PIN_SECOND_EN = wake_b;
	assign O_FSI_HOLD = hold;
	assign O_FSI_ON_SECOND = on_sec;

	// ***************************************************************
	// Assertions
	// ***************************************************************
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (I_SYS_RST);

	sequence wr_a(logic [7:0] c);
		I_WR && !I_CFG_LOAD && I_ADDR == `CIMS_OFS_CMD_A && I_WDATA[7:0] == c && bm_a != cims_pkg::CIMS_BM_MCU;
	endsequence
	sequence release_seq;
		bm_a == cims_pkg::CIMS_BM_NONE ##1 O_FIRST_CHANNEL_CONTROL_BUS_OE == `CIMS_STB_NONE;
	endsequence

	multi_protocol_serial_engine_first_only_a: assert property (bm_b != cims_pkg::CIMS_BM_MULTI_PROTOCOL_SERIAL_ENGINE) // [R05]
		else $error("engine on second");
	mcu_both_ch_a: assert property (bm_a == cims_pkg::CIMS_BM_MCU |-> bm_b == cims_pkg::CIMS_BM_MCU) // [R06]
		else $error("emulation split");
	bb_fsi_block_a: assert property (main_b == cims_pkg::CIMS_MAIN_FSI |-> !sb.bb_active) // [R10]
		else $error("bit-bang over isolated");
	async_decode_a: assert property (wr_a(`CIMS_CMD_ASYNC_BB) |=> bm_a == cims_pkg::CIMS_BM_ASYNC) // [R02]
		else $error("code 1 missed");
	sync_decode_a: assert property (wr_a(`CIMS_CMD_SYNC_BB) |=> bm_a == cims_pkg::CIMS_BM_SYNC) // [R03]
		else $error("code 4 missed");
	fsi_hold_set_a: assert property (main_a == cims_pkg::CIMS_MAIN_FSI ##0 wr_a(`CIMS_CMD_FSI) // [R04]
		|=> hold[0]) else $error("hold not set");
	uart_strobe_a: assert property (sa.bb_active && sa.uart_main |=> // [R09]
		O_FIRST_CHANNEL_CONTROL_BUS_OE == `CIMS_STB_MASK_HIGH) else $error("uart strobes misplaced");
	fifo_strobe_a: assert property (sa.bb_active && !sa.uart_main |=> // [R08]
		O_FIRST_CHANNEL_CONTROL_BUS_OE == `CIMS_STB_MASK_LOW) else $error("fifo strobes misplaced");
	wake_off_a: assert property (bm_a == cims_pkg::CIMS_BM_MULTI_PROTOCOL_SERIAL_ENGINE |=> !O_SEND_NOW_WAKE_PIN_FIRST_EN) // [R11]
		else $error("wake left on");
	bad_cmd_a: assert property (wr_a(8'h03) |=> $stable(bm_a) && $stable(last_a)) // [R14]
		else $error("bad code acted");
	blank_uart_a: assert property (I_CFG_LOAD && I_CFG_BLANK |=> // [R12]
		main_a == cims_pkg::CIMS_MAIN_UART && main_b == cims_pkg::CIMS_MAIN_UART) else $error("blank not uart");
	bm_release_a: assert property (wr_a(`CIMS_CMD_RESET) |=> release_seq) // [R13]
		else $error("strobes not removed");
endmodule

`default_nettype wire

// *** verif/cims_host_model.sv ***
// Host-side partner model that issues register accesses and mode commands
`timescale 1ns/1ps
`default_nettype none
`include "cims_consts.svh"

module cims_host_model (
	// Clock
	input wire logic i_clk,
	// Register port toward the block
	output logic [7:0] o_addr,
	output logic [31:0] o_wdata,
	output logic o_wr,
	output logic o_rd,
	input wire logic [31:0] i_rdata
);
	// ***************************************************************
	// Bus cycles
	// ***************************************************************
	initial begin
		o_addr = 8'h00;
		o_wdata = 32'h0000_0000;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end

	// One write cycle; idle lines are inverted so stale values never look live
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask

	// One read cycle; data are taken mid-cycle after the strobe, the only cycle they stand
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		@(negedge i_clk);
		d = i_rdata;
	endtask

	// Command encoding
	// Command byte sits in the low bits; upper bits left clear
	task automatic cmd(input logic ch_b, input logic [7:0] code);
		wr(ch_b ? `CIMS_OFS_CMD_B : `CIMS_OFS_CMD_A, {24'h00_0000, code});
	endtask
endmodule

`default_nettype wire

// *** verif/tb.sv ***
// Self-checking testbench of the channel I/O mode select block
`timescale 1ns/1ps
`default_nettype none
`include "cims_consts.svh"

module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cfg_load = 1'b0;
	logic cfg_present = 1'b0;
	logic cfg_blank = 1'b0;
	logic [1:0] cfg_a = 2'b00;
	logic [1:0] cfg_b = 2'b00;
	logic [3:0] bb = 4'h0;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	logic [3:0] bus_a, oe_a, bus_b, oe_b, pf_a, pf_b;
	logic wake_a, wake_b, on_sec;
	logic [1:0] hold;
	logic [31:0] rv;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;

	// ***************************************************************
	// Clock, design and partner
	// ***************************************************************
	initial begin
		forever #4 clk = ~clk;
	end

	cims_mode_select DUT (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_CFG_LOAD(cfg_load), .I_CFG_PRESENT(cfg_present),
		.I_CFG_BLANK(cfg_blank), .I_CFG_MODE_A(cfg_a), .I_CFG_MODE_B(cfg_b), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_BB_WR_A(bb[0]), .I_BB_RD_A(bb[1]), .I_BB_WR_B(bb[2]),
		.I_BB_RD_B(bb[3]), .O_FIRST_CHANNEL_CONTROL_BUS(bus_a), .O_FIRST_CHANNEL_CONTROL_BUS_OE(oe_a),
		.O_SECOND_CHANNEL_CONTROL_BUS(bus_b), .O_SECOND_CHANNEL_CONTROL_BUS_OE(oe_b), .O_PIN_FUNC_A(pf_a),
		.O_PIN_FUNC_B(pf_b), .O_SEND_NOW_WAKE_PIN_FIRST_EN(wake_a), .O_SEND_NOW_WAKE_PIN_SECOND_EN(wake_b),
		.O_FSI_HOLD(hold), .O_FSI_ON_SECOND(on_sec));

	cims_host_model host (.i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd), .i_rdata(rdata));

	// ***************************************************************
	// Checking helpers
	// ***************************************************************
	task automatic finish_test;
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	// Pin functions take two edges after a command; three leaves margin
	task automatic pins(input logic [3:0] fa, fb, ea, eb, input logic wa, wb);
		idle(3);
		chk({pf_a, pf_b, oe_a, oe_b}, {fa, fb, ea, eb});
		chk({wake_a, wake_b}, {wa, wb});
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		host.rd(a, rv);
		chk(rv, exp);
	endtask

	// Strobe in one cycle, bus answers one cycle later, then strobes drop
	task automatic stb(input logic [3:0] s, input logic [3:0] xa, input logic [3:0] xb);
		@(posedge clk);
		bb <= s;
		@(posedge clk);
		@(negedge clk);
		chk({bus_a, bus_b}, {xa, xb});
		@(posedge clk);
		bb <= 4'h0;
	endtask

	task automatic cfg(input logic p, input logic b, input logic [1:0] ma, input logic [1:0] mb);
		@(posedge clk);
		cfg_present <= p;
		cfg_blank <= b;
		cfg_a <= ma;
		cfg_b <= mb;
		cfg_load <= 1'b1;
		@(posedge clk);
		cfg_load <= 1'b0;
	endtask

	// Hang guard: the sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			error_cnt++;
			$display("[ERR] %0t run did not finish in time", $time);
			finish_test();
		end
	end

	// ***************************************************************
	// Test sequence
	// ***************************************************************
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		pins(4'h0, 4'h0, 4'h0, 4'h0, 1'b1, 1'b1);
		chk({bus_a, bus_b}, 8'hff);
		rd_chk(`CIMS_OFS_STATUS, 32'h0);
		cfg(1'b1, 1'b0, 2'd1, 2'd2);
		pins(4'h1, 4'h2, 4'h0, 4'h0, 1'b1, 1'b0);
		rd_chk(`CIMS_OFS_STATUS, 32'h9);
		host.cmd(1'b0, `CIMS_CMD_FSI);
		pins(4'h1, 4'h2, 4'h0, 4'h0, 1'b1, 1'b0);
		rd_chk(`CIMS_OFS_CMD_A, 32'h0);
		host.cmd(1'b0, `CIMS_CMD_ASYNC_BB);
		pins(4'h4, 4'h2, 4'h3, 4'h0, 1'b1, 1'b0);
		stb(4'b0001, 4'he, 4'hf);
		stb(4'b0010, 4'hd, 4'hf);
		rd_chk(`CIMS_OFS_CMD_A, 32'h1);
		host.cmd(1'b1, `CIMS_CMD_MULTI_PROTOCOL_SERIAL_ENGINE);
		pins(4'h4, 4'h2, 4'h3, 4'h0, 1'b1, 1'b0);
		rd_chk(`CIMS_OFS_CMD_B, 32'h0);
		host.cmd(1'b0, 8'h03);
		pins(4'h4, 4'h2, 4'h3, 4'h0, 1'b1, 1'b0);
		host.cmd(1'b0, `CIMS_CMD_MULTI_PROTOCOL_SERIAL_ENGINE);
		pins(4'h6, 4'h2, 4'h0, 4'h0, 1'b0, 1'b0);
		host.cmd(1'b0, `CIMS_CMD_RESET);
		pins(4'h1, 4'h2, 4'h0, 4'h0, 1'b1, 1'b0);
		host.cmd(1'b1, `CIMS_CMD_SYNC_BB);
		pins(4'h1, 4'h5, 4'h0, 4'h3, 1'b1, 1'b0);
		stb(4'b0100, 4'hf, 4'he);
		rd_chk(`CIMS_OFS_STATUS, 32'h3009);
		rd_chk(`CIMS_OFS_PINFN, 32'h51);
		host.cmd(1'b0, `CIMS_CMD_MCU);
		pins(4'h7, 4'h7, 4'h0, 4'h0, 1'b0, 1'b0);
		host.cmd(1'b1, `CIMS_CMD_ASYNC_BB);
		pins(4'h7, 4'h7, 4'h0, 4'h0, 1'b0, 1'b0);
		host.cmd(1'b1, `CIMS_CMD_RESET);
		pins(4'h1, 4'h2, 4'h0, 4'h0, 1'b1, 1'b0);
		cfg(1'b1, 1'b0, 2'd0, 2'd0);
		host.cmd(1'b0, `CIMS_CMD_ASYNC_BB);
		pins(4'h4, 4'h0, 4'hc, 4'h0, 1'b1, 1'b1);
		stb(4'b0001, 4'hb, 4'hf);
		stb(4'b0010, 4'h7, 4'hf);
		host.cmd(1'b1, `CIMS_CMD_SYNC_BB);
		pins(4'h4, 4'h5, 4'hc, 4'hc, 1'b1, 1'b1);
		stb(4'b1000, 4'hf, 4'h7);
		cfg(1'b1, 1'b1, 2'd1, 2'd2);
		pins(4'h0, 4'h0, 4'h0, 4'h0, 1'b1, 1'b1);
		cfg(1'b0, 1'b0, 2'd2, 2'd2);
		pins(4'h0, 4'h0, 4'h0, 4'h0, 1'b1, 1'b1);
		cfg(1'b1, 1'b0, 2'd0, 2'd3);
		pins(4'h0, 4'h3, 4'h0, 4'h0, 1'b1, 1'b1);
		host.cmd(1'b1, `CIMS_CMD_ASYNC_BB);
		pins(4'h0, 4'h3, 4'h0, 4'h0, 1'b1, 1'b1);
		host.cmd(1'b0, `CIMS_CMD_ASYNC_BB);
		pins(4'h4, 4'h3, 4'hc, 4'h0, 1'b1, 1'b1);
		host.cmd(1'b1, `CIMS_CMD_FSI);
		idle(3);
		chk(hold, 2'b10);
		host.cmd(1'b1, `CIMS_CMD_RESET);
		idle(3);
		chk(hold, 2'b00);
		cfg(1'b1, 1'b0, 2'd3, 2'd3);
		idle(4);
		chk({pf_a, pf_b, 3'h0, on_sec}, {4'h8, 4'h3, 4'h1});
		rd_chk(`CIMS_OFS_STATUS, 32'h4f);
		// Isolated serial held and released on the first channel, then an overlay on top of it
		host.cmd(1'b0, `CIMS_CMD_FSI);
		idle(3);
		chk(hold, 2'b01);
		host.cmd(1'b0, `CIMS_CMD_RESET);
		idle(3);
		chk(hold, 2'b00);
		host.cmd(1'b0, `CIMS_CMD_SYNC_BB);
		pins(4'h5, 4'h3, 4'h3, 4'h0, 1'b0, 1'b1);
		stb(4'b0010, 4'hd, 4'hf);
		host.cmd(1'b1, `CIMS_CMD_MCU);
		pins(4'h7, 4'h7, 4'h0, 4'h0, 1'b0, 1'b0);
		rd_chk(`CIMS_OFS_CMD_B, 32'h8);
		host.cmd(1'b0, `CIMS_CMD_RESET);
		pins(4'h8, 4'h3, 4'h0, 4'h0, 1'b0, 1'b1);
		// A reset in mid-run must bring every output back to its power-up value
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		pins(4'h0, 4'h0, 4'h0, 4'h0, 1'b1, 1'b1);
		chk({hold, on_sec, bus_a, bus_b}, 11'h0ff);
		rd_chk(`CIMS_OFS_CMD_B, 32'h0);
		finish_test();
	end
endmodule

`default_nettype wire
